// file: rtl/acsc_pkg.sv
package acsc_pkg;

    // ==========================================================
    // Bus geometry
    localparam int          ADR_W            = 10;
    localparam int          DAT_W            = 32;
    localparam int          IDX_W            = 8;

    // ==========================================================
    // Register indices (byte address is four times the index)
    localparam logic [7:0]  IDX_STATUS       = 8'h6a;
    localparam logic [7:0]  IDX_PIN_SETUP    = 8'h6b;
    localparam logic [7:0]  IDX_SOFT_KICK    = 8'h6c;
    localparam logic [7:0]  IDX_LP_CTRL      = 8'h6e;
    localparam logic [7:0]  IDX_IRQ_STATUS   = 8'h80;
    localparam logic [7:0]  IDX_IRQ_MASK     = 8'h81;

    // ==========================================================
    // Reset values
    localparam logic [7:0]  PIN_SETUP_RST    = 8'h00;
    localparam logic [7:0]  SOFT_KICK_RST    = 8'h01;
    localparam logic [7:0]  LP_CTRL_RST      = 8'h88;
    localparam logic [3:0]  IRQ_MASK_RST     = 4'h0;

    // ==========================================================
    // Field positions
    localparam int          PIN_TRIG_SRC_BIT = 0;
    localparam int          PIN_STAT_SEL_LSB = 1;
    localparam int          KICK_BIT         = 0;
    localparam int          STAT_FG_BIT      = 0;
    localparam int          STAT_STOP_BIT    = 1;
    localparam int          STAT_CODE_LSB    = 2;
    localparam int          LOW_POWER_RECAL_ENABLE_BIT        = 0;
    localparam int          LP_POLICY_BIT    = 1;
    localparam int          LP_WAKE_LSB      = 3;
    localparam int          LP_SLEEP_LSB     = 5;

    // ==========================================================
    // Status pin selector codes
    localparam logic [1:0]  SEL_FOREGROUND_COMPLETE_FLAG      = 2'h0;
    localparam logic [1:0]  SEL_STOPPED      = 2'h1;
    localparam logic [1:0]  SEL_ALARM        = 2'h2;
    localparam logic [1:0]  SEL_LOW          = 2'h3;

    // ==========================================================
    // Interrupt event bits
    localparam int          EV_N             = 4;
    localparam int          EV_FOREGROUND_COMPLETE_FLAG       = 0;
    localparam int          EV_STOPPED       = 1;
    localparam int          EV_RESUMED       = 2;
    localparam int          EV_ALARM         = 3;

    // ==========================================================
    // Low-power timing
    localparam int          LP_UNIT_CYCLES   = 256;
    localparam int          LP_CNT_W         = 42;
    localparam int          LP_EXP_W         = 6;

    typedef enum logic [3:0] {
        ACSC_LP_IDLE   = 4'b0001,
        ACSC_LP_SLEEP  = 4'b0010,
        ACSC_LP_SETTLE = 4'b0100,
        ACSC_LP_CALIB  = 4'b1000
    } acsc_lp_state_t;

    // Sleep exponent per code
    function automatic logic [5:0] sleep_exp(input logic [2:0] code);
        case (code)
            3'h0: sleep_exp = 6'h03;
            3'h1: sleep_exp = 6'h0f;
            3'h2: sleep_exp = 6'h12;
            3'h3: sleep_exp = 6'h15;
            3'h4: sleep_exp = 6'h18;
            3'h5: sleep_exp = 6'h1b;
            3'h6: sleep_exp = 6'h1e;
            default: sleep_exp = 6'h21;
        endcase
    endfunction : sleep_exp

    // Wake settling exponent per code
    function automatic logic [5:0] wake_exp(input logic [1:0] code);
        case (code)
            2'h0: wake_exp = 6'h03;
            2'h1: wake_exp = 6'h12;
            2'h2: wake_exp = 6'h15;
            default: wake_exp = 6'h18;
        endcase
    endfunction : wake_exp

endpackage : acsc_pkg

// file: rtl/acsc_lp_if.sv
`timescale 1ns/10ps
interface acsc_lp_if;
    logic       enable;
    logic       policy;
    logic [2:0] sleep_code;
    logic [1:0] wake_code;
    logic       trigger;
    logic       cal_done;
    logic       sleeping;
    logic       settling;
    logic       cal_req;

    modport ctrl  (output enable, policy, sleep_code, wake_code, trigger, cal_done,
                   input  sleeping, settling, cal_req);
    modport timer (input  enable, policy, sleep_code, wake_code, trigger, cal_done,
                   output sleeping, settling, cal_req);
endinterface : acsc_lp_if

// file: rtl/acsc_lp_timer.sv
`timescale 1ns/10ps
module acsc_lp_timer #(
    parameter logic [5:0]  EXP_MAX = 6'h21,
    parameter int          UNIT    = acsc_pkg::LP_UNIT_CYCLES
) (
    input  wire logic      clk,
    input  wire logic      rst,
    acsc_lp_if.timer       lp
);

    acsc_pkg::acsc_lp_state_t          state;
    logic [acsc_pkg::LP_CNT_W-1:0]     count;

    // ==========================================================
    // Delay span: (2^N + 1) x unit clock periods
    function automatic logic [acsc_pkg::LP_CNT_W-1:0] span(input logic [5:0] e);
        logic [5:0] ec;
        ec   = (e > EXP_MAX) ? EXP_MAX : e;
        span = ((acsc_pkg::LP_CNT_W'(1) << ec) + acsc_pkg::LP_CNT_W'(1))
               * acsc_pkg::LP_CNT_W'(UNIT);
    endfunction : span

    // ==========================================================
    // Sleep / settle / calibrate sequence
    // Dropping enable aborts at once, so a core never stays asleep
    always_ff @(posedge clk) begin
        if (rst || !lp.enable) begin // R14
            state <= acsc_pkg::ACSC_LP_IDLE;
            count <= '0;
        end else begin
            case (state)
                acsc_pkg::ACSC_LP_IDLE: begin
                    state <= acsc_pkg::ACSC_LP_SLEEP;
                    count <= span(acsc_pkg::sleep_exp(lp.sleep_code)); // R09
                end
                acsc_pkg::ACSC_LP_SLEEP: begin
                    if (lp.policy ? !lp.trigger : (count <= 1)) begin // R13
                        state <= acsc_pkg::ACSC_LP_SETTLE;
                        count <= span(acsc_pkg::wake_exp(lp.wake_code)); // R11
                    end else if (!lp.policy) begin
                        count <= count - 1'b1;
                    end
                end
                acsc_pkg::ACSC_LP_SETTLE: begin
                    if (count <= 1) begin // R11
                        state <= acsc_pkg::ACSC_LP_CALIB;
                    end else begin
                        count <= count - 1'b1;
                    end
                end
                acsc_pkg::ACSC_LP_CALIB: begin
                    if (lp.cal_done) begin
                        state <= acsc_pkg::ACSC_LP_SLEEP;
                        count <= span(acsc_pkg::sleep_exp(lp.sleep_code)); // R09
                    end
                end
                default: begin
                    state <= acsc_pkg::ACSC_LP_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Registered phase outputs
    always_ff @(posedge clk) begin
        if (rst) begin
            lp.sleeping <= 1'b0;
            lp.settling <= 1'b0;
            lp.cal_req  <= 1'b0;
        end else begin
            lp.sleeping <= lp.enable && (state == acsc_pkg::ACSC_LP_SLEEP);
            lp.settling <= lp.enable && (state == acsc_pkg::ACSC_LP_SETTLE);
            lp.cal_req  <= lp.enable && (state == acsc_pkg::ACSC_LP_CALIB) && !lp.cal_done;
        end
    end

endmodule : acsc_lp_timer

// file: rtl/acsc_top.sv
// Summary of operation
// R01: The stopped flag (status bit 1) goes high once background calibration has halted at the requested phase.
// R02: The stopped flag returns to zero as soon as calibration runs again.
// R03: With background calibration off, the stopped flag is set when foreground calibration ends or is skipped.
// R04: The read-only foreground-complete flag (status bit 0) is high once foreground calibration ended or was skipped.
// R05: The 2-bit selector at bits 2:1 routes 0 fg-complete, 1 stopped, 2 alarm, 3 constant low to the status pin.
// R06: With trigger-source select at 0 the trigger is the software bit and the hardware pin is ignored.
// R07: With trigger-source select at 1 the trigger is the hardware pin and the software bit is ignored.
// R08: Software needing no trigger should keep the source select at 0 and the software bit (reset 1) high.
// R09: In autonomous low-power mode the sleep field 7:5 sets sleep to (2^N+1)x256 clocks, N = 3,15,18,...,33.
// R10: Software should not program the sleep field below 4.
// R11: The wake field 4:3 sets the settling wait after wake to (2^N+1)x256 clocks, N = 3,18,21,24.
// R12: Software should not program the wake field below 1.
// R13: The wake policy bit picks timed sleep at 0, or sleep until the trigger goes low at 1.
// R14: Low-power calibration runs only while its enable bit and background calibration are both set.
// R15: Software must not touch the calibration data port while the stopped flag is zero.
// R16: Reserved status bits read as zero and writes to them do nothing.
//
// The Wishbone slave port is this design's own decision.
`timescale 1ns/10ps
module acsc_top #(
    parameter logic [5:0] LP_EXP_MAX = 6'h21
) (
    input  wire logic                         MCLK,
    input  wire logic                         RESET,
    input  wire logic                         WB_CYC_I,
    input  wire logic                         WB_STB_I,
    input  wire logic                         WB_WE_I,
    input  wire logic [acsc_pkg::ADR_W-1:0]   WB_ADR_I,
    input  wire logic [3:0]                   WB_SEL_I,
    input  wire logic [acsc_pkg::DAT_W-1:0]   WB_DAT_I,
    output logic      [acsc_pkg::DAT_W-1:0]   WB_DAT_O,
    output logic                              WB_ACK_O,
    input  wire logic                         BACKGROUND_RECAL_ENABLE,
    input  wire logic                         FG_CAL_DONE,
    input  wire logic                         CAL_RESTART,
    input  wire logic                         BG_HALTED,
    input  wire logic [2:0]                   CAL_STATE_CODE,
    input  wire logic                         ALARM,
    input  wire logic                         HARDWARE_TRIGGER_PIN,
    input  wire logic                         CORE_CAL_DONE,
    output logic                              CALIBRATION_STATUS_PIN,
    output logic                              CAL_TRIGGER,
    output logic                              CORE_SLEEP,
    output logic                              CORE_SETTLE,
    output logic                              CORE_CAL_REQ,
    output logic                              IRQ
);

    // ==========================================================
    // Declarations
    logic [7:0]                   pin_setup;
    logic [7:0]                   soft_kick;
    logic [7:0]                   lp_ctrl;
    logic [acsc_pkg::EV_N-1:0]    irq_status;
    logic [acsc_pkg::EV_N-1:0]    irq_mask;
    logic                         fg_flag;
    logic                         stopped_flag;
    logic                         next_fg_flag;
    logic                         next_stopped_flag;
    logic                         alarm_q;
    logic                         trig_meta;
    logic                         trig_sync;
    logic                         next_trigger;
    logic                         bus_req;
    logic                         bus_wr;
    logic [acsc_pkg::IDX_W-1:0]   bus_idx;
    logic [acsc_pkg::EV_N-1:0]    events;

    acsc_lp_if lp_bus ();

    // ==========================================================
    // Register decode, shared by write and read paths
    function automatic logic hit(input logic [acsc_pkg::IDX_W-1:0] idx,
                                 input logic [acsc_pkg::IDX_W-1:0] reg_idx);
        hit = (idx == reg_idx);
    endfunction : hit

    // Only the low byte lane carries data; other lanes are don't-care
    assign bus_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    assign bus_wr  = bus_req && WB_WE_I && WB_SEL_I[0];
    assign bus_idx = WB_ADR_I[acsc_pkg::ADR_W-1:2];

    // ==========================================================
    // Hardware trigger pin synchroniser
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            trig_meta <= 1'b0;
            trig_sync <= 1'b0;
        end else begin
            trig_meta <= HARDWARE_TRIGGER_PIN;
            trig_sync <= trig_meta;
        end
    end

    // ==========================================================
    // Software-writable configuration
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            pin_setup <= acsc_pkg::PIN_SETUP_RST;
            soft_kick <= acsc_pkg::SOFT_KICK_RST; // R08
            lp_ctrl   <= acsc_pkg::LP_CTRL_RST;
            irq_mask  <= acsc_pkg::IRQ_MASK_RST;
        end else if (bus_wr) begin
            if (hit(bus_idx, acsc_pkg::IDX_PIN_SETUP)) begin
                pin_setup <= WB_DAT_I[7:0];
            end
            if (hit(bus_idx, acsc_pkg::IDX_SOFT_KICK)) begin
                soft_kick <= WB_DAT_I[7:0];
            end
            if (hit(bus_idx, acsc_pkg::IDX_LP_CTRL)) begin
                lp_ctrl <= WB_DAT_I[7:0];
            end
            if (hit(bus_idx, acsc_pkg::IDX_IRQ_MASK)) begin
                irq_mask <= WB_DAT_I[acsc_pkg::EV_N-1:0];
            end
        end
    end

    // ==========================================================
    // Calibration state flags
    // A done pulse in the restart cycle still sets the flag
    always_comb begin
        next_fg_flag = fg_flag;
        if (CAL_RESTART) begin
            next_fg_flag = 1'b0;
        end
        if (FG_CAL_DONE) begin
            next_fg_flag = 1'b1; // R04
        end
        if (BACKGROUND_RECAL_ENABLE) begin
            next_stopped_flag = BG_HALTED; // R01 R02
        end else begin
            next_stopped_flag = next_fg_flag; // R03
        end
    end

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            fg_flag      <= 1'b0;
            stopped_flag <= 1'b0;
            alarm_q      <= 1'b0;
        end else begin
            fg_flag      <= next_fg_flag; // R04
            stopped_flag <= next_stopped_flag; // R01 R02 R03
            alarm_q      <= ALARM;
        end
    end

    // ==========================================================
    // Interrupt events, sticky and write-one-to-clear
    assign events[acsc_pkg::EV_FOREGROUND_COMPLETE_FLAG] = next_fg_flag && !fg_flag;
    assign events[acsc_pkg::EV_STOPPED] = next_stopped_flag && !stopped_flag;
    assign events[acsc_pkg::EV_RESUMED] = !next_stopped_flag && stopped_flag;
    assign events[acsc_pkg::EV_ALARM]   = ALARM && !alarm_q;

    // Set beats clear so an event in the clearing cycle survives
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            irq_status <= '0;
        end else if (bus_wr && hit(bus_idx, acsc_pkg::IDX_IRQ_STATUS)) begin
            irq_status <= (irq_status & ~WB_DAT_I[acsc_pkg::EV_N-1:0]) | events;
        end else begin
            irq_status <= irq_status | events;
        end
    end

    // One cycle behind the status bit; harmless for a level line
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(irq_status & irq_mask);
        end
    end

    // ==========================================================
    // Trigger source and status pin routing
    always_comb begin
        if (pin_setup[acsc_pkg::PIN_TRIG_SRC_BIT]) begin
            next_trigger = trig_sync; // R07
        end else begin
            next_trigger = soft_kick[acsc_pkg::KICK_BIT]; // R06
        end
    end

    always_ff @(posedge MCLK) begin
        if (RESET) begin
            CAL_TRIGGER            <= 1'b0;
            CALIBRATION_STATUS_PIN <= 1'b0;
        end else begin
            CAL_TRIGGER <= next_trigger;
            case (pin_setup[acsc_pkg::PIN_STAT_SEL_LSB +: 2]) // R05
                acsc_pkg::SEL_FOREGROUND_COMPLETE_FLAG: CALIBRATION_STATUS_PIN <= fg_flag;
                acsc_pkg::SEL_STOPPED: CALIBRATION_STATUS_PIN <= stopped_flag;
                acsc_pkg::SEL_ALARM:   CALIBRATION_STATUS_PIN <= alarm_q;
                default:               CALIBRATION_STATUS_PIN <= 1'b0;
            endcase
        end
    end

    // ==========================================================
    // Low-power sleep and wake sequencer
    assign lp_bus.enable     = lp_ctrl[acsc_pkg::LOW_POWER_RECAL_ENABLE_BIT] && BACKGROUND_RECAL_ENABLE; // R14
    assign lp_bus.policy     = lp_ctrl[acsc_pkg::LP_POLICY_BIT];
    assign lp_bus.sleep_code = lp_ctrl[acsc_pkg::LP_SLEEP_LSB +: 3];
    assign lp_bus.wake_code  = lp_ctrl[acsc_pkg::LP_WAKE_LSB +: 2];
    assign lp_bus.trigger    = CAL_TRIGGER;
    assign lp_bus.cal_done   = CORE_CAL_DONE;

    acsc_lp_timer #(
        .EXP_MAX (LP_EXP_MAX),
        .UNIT    (acsc_pkg::LP_UNIT_CYCLES)
    ) u_lp_timer (
        .clk     (MCLK),
        .rst     (RESET),
        .lp      (lp_bus)
    );

    assign CORE_SLEEP   = lp_bus.sleeping;
    assign CORE_SETTLE  = lp_bus.settling;
    assign CORE_CAL_REQ = lp_bus.cal_req;

    // ==========================================================
    // Wishbone answer: one wait state, unmapped reads give zero
    always_ff @(posedge MCLK) begin
        if (RESET) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= '0;
        end else begin
            WB_ACK_O <= bus_req;
            if (bus_req && !WB_WE_I) begin
                WB_DAT_O <= '0;
                if (hit(bus_idx, acsc_pkg::IDX_STATUS)) begin
                    // Upper status bits are fixed zero
                    WB_DAT_O[acsc_pkg::STAT_FG_BIT]          <= fg_flag; // R04
                    WB_DAT_O[acsc_pkg::STAT_STOP_BIT]        <= stopped_flag; // R01
                    WB_DAT_O[acsc_pkg::STAT_CODE_LSB +: 3]   <= CAL_STATE_CODE; // R16
                end
                if (hit(bus_idx, acsc_pkg::IDX_PIN_SETUP)) begin
                    WB_DAT_O[7:0] <= pin_setup;
                end
                if (hit(bus_idx, acsc_pkg::IDX_SOFT_KICK)) begin
                    WB_DAT_O[7:0] <= soft_kick;
                end
                if (hit(bus_idx, acsc_pkg::IDX_LP_CTRL)) begin
                    WB_DAT_O[7:0] <= lp_ctrl;
                end
                if (hit(bus_idx, acsc_pkg::IDX_IRQ_STATUS)) begin
                    WB_DAT_O[acsc_pkg::EV_N-1:0] <= irq_status;
                end
                if (hit(bus_idx, acsc_pkg::IDX_IRQ_MASK)) begin
                    WB_DAT_O[acsc_pkg::EV_N-1:0] <= irq_mask;
                end
            end else begin
                WB_DAT_O <= '0;
            end
        end
    end

endmodule : acsc_top

// file: testbench/acsc_top_props.sv
`timescale 1ns/10ps
module acsc_top_props #(
    parameter logic [5:0] LP_EXP_MAX = 6'h21
) (
    input  logic                       MCLK,
    input  logic                       RESET,
    input  logic                       WB_CYC_I,
    input  logic                       WB_STB_I,
    input  logic                       WB_WE_I,
    input  logic [acsc_pkg::ADR_W-1:0] WB_ADR_I,
    input  logic [acsc_pkg::DAT_W-1:0] WB_DAT_O,
    input  logic                       WB_ACK_O,
    input  logic                       BACKGROUND_RECAL_ENABLE,
    input  logic                       FG_CAL_DONE,
    input  logic                       BG_HALTED,
    input  logic                       CORE_CAL_DONE,
    input  logic                       CORE_SLEEP,
    input  logic                       CORE_SETTLE,
    input  logic                       CORE_CAL_REQ
);
    // Exact only while the cap pins every exponent
    localparam int SETTLE_LEN = (2 ** LP_EXP_MAX + 1) * acsc_pkg::LP_UNIT_CYCLES;
    logic [31:0] settle_cnt;

    default clocking @(posedge MCLK); endclocking
    default disable iff (RESET);

    // Settle phase length so far
    always_ff @(posedge MCLK) begin
        if (RESET) settle_cnt <= 32'h0;
        else settle_cnt <= CORE_SETTLE ? settle_cnt + 32'h1 : 32'h0;
    end

    // ==========================================================
    // Sequences
    sequence st_ack_s;
        WB_ACK_O && $past(WB_STB_I && !WB_WE_I && WB_ADR_I[9:2] == acsc_pkg::IDX_STATUS);
    endsequence
    sequence bg_off_s;
        (!BACKGROUND_RECAL_ENABLE) [*4];
    endsequence

    // ==========================================================
    // Assertions
    ack_answer_a: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
        else $error("request not acked next cycle");
    ack_single_a: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack too long");
    dat_idle_a: assert property (!WB_ACK_O |-> WB_DAT_O == '0)
        else $error("read data not zero");
    stat_rsvd_a: assert property (st_ack_s |-> WB_DAT_O[31:5] == '0)
        else $error("reserved status bits set");
    fg_flag_a: assert property (FG_CAL_DONE ##2 st_ack_s |-> WB_DAT_O[0])
        else $error("foreground flag low");
    stop_fg_a: assert property ((FG_CAL_DONE && !BACKGROUND_RECAL_ENABLE) [*2] ##2 st_ack_s |-> WB_DAT_O[1])
        else $error("stopped flag not following foreground");
    stop_halt_a: assert property ((BG_HALTED && BACKGROUND_RECAL_ENABLE) [*2] ##2 st_ack_s |-> WB_DAT_O[1])
        else $error("stopped flag low while halted");
    stop_run_a: assert property ((!BG_HALTED && BACKGROUND_RECAL_ENABLE) [*2] ##2 st_ack_s |-> !WB_DAT_O[1])
        else $error("stopped flag high while running");
    lp_off_a: assert property (bg_off_s |-> !CORE_SLEEP && !CORE_SETTLE && !CORE_CAL_REQ)
        else $error("low-power phase with background off");
    phase_one_a: assert property ($onehot0({CORE_SLEEP, CORE_SETTLE, CORE_CAL_REQ}))
        else $error("several low-power phases");
    settle_len_a: assert property (BACKGROUND_RECAL_ENABLE [*3] ##0 (LP_EXP_MAX <= 3) && $fell(CORE_SETTLE)
        |-> settle_cnt == SETTLE_LEN)
        else $error("settle length wrong");
    req_hold_a: assert property ((BACKGROUND_RECAL_ENABLE && !CORE_CAL_DONE) [*2] ##0 CORE_CAL_REQ
        |=> CORE_CAL_REQ)
        else $error("calibration request dropped");
endmodule : acsc_top_props

bind acsc_top acsc_top_props #(.LP_EXP_MAX(LP_EXP_MAX)) acsc_top_props_inst (.*);

// file: testbench/acsc_top_tb.sv
`timescale 1ns/10ps
module acsc_top_tb;
    logic        mclk = 1'b0, rst = 1'b1, req = 1'b0, we = 1'b0, ack, stp, trg, slp, stl, creq, irq;
    logic        bre = 1'b0, fgd = 1'b0, rsr = 1'b0, hlt = 1'b0, alm = 1'b0, hwp = 1'b1, ccd = 1'b0;
    logic [9:0]  adr = 10'h0;
    logic [2:0]  code = 3'h0;
    logic [31:0] wdat = 32'h0, rdat;
    int          n_errors = 0, cmp_count = 0, n;

    // ==========================================================
    // Clock, device and watchdog
    always #2.5 mclk = ~mclk;

    acsc_top #(.LP_EXP_MAX(6'h03)) acsc_top_inst (
        .MCLK(mclk), .RESET(rst), .WB_CYC_I(req), .WB_STB_I(req), .WB_WE_I(we), .WB_ADR_I(adr),
        .WB_SEL_I(4'h1), .WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .BACKGROUND_RECAL_ENABLE(bre),
        .FG_CAL_DONE(fgd), .CAL_RESTART(rsr), .BG_HALTED(hlt), .CAL_STATE_CODE(code), .ALARM(alm),
        .HARDWARE_TRIGGER_PIN(hwp), .CORE_CAL_DONE(ccd), .CALIBRATION_STATUS_PIN(stp), .CAL_TRIGGER(trg),
        .CORE_SLEEP(slp), .CORE_SETTLE(stl), .CORE_CAL_REQ(creq), .IRQ(irq));

    // Run is about 8k cycles; give it five times that
    initial begin
        #200000;
        n_errors++;
        end_sim();
    end

    // ==========================================================
    // Shared tasks
    task automatic end_sim();
        $display("tests done: %0d compares, %0d mismatches", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : end_sim

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        cmp_count++;
        if (got !== exp) begin
            n_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
        end
    endtask : chk

    task automatic tick(input int k);
        repeat (k) @(posedge mclk);
    endtask : tick

    // One classic cycle; no assumption on how soon ack comes
    task automatic wb(input logic w, input logic [7:0] idx, input logic [7:0] wd, output logic [31:0] rd);
        int k;
        @(posedge mclk);
        req  <= 1'b1;
        we   <= w;
        adr  <= {idx, 2'b00};
        wdat <= {24'h0, wd};
        k = 0;
        do @(posedge mclk); while (ack !== 1'b1 && ++k < 50);
        rd = rdat;
        req <= 1'b0;
        chk("ack", 1, ack);
    endtask : wb

    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] x;
        wb(1'b1, idx, d, x);
    endtask : wr

    task automatic rdc(input string what, input logic [7:0] idx, input logic [31:0] exp);
        logic [31:0] x;
        wb(1'b0, idx, 8'h0, x);
        chk(what, exp, x);
    endtask : rdc

    // ==========================================================
    // Scenarios
    task automatic t_reset();
        rdc("pin setup reset", acsc_pkg::IDX_PIN_SETUP, 32'h00);
        rdc("kick reset", acsc_pkg::IDX_SOFT_KICK, 32'h01);
        rdc("lp reset", acsc_pkg::IDX_LP_CTRL, 32'h88);
        rdc("unmapped", 8'h10, 32'h0);
        wr(acsc_pkg::IDX_PIN_SETUP, 8'hf8);
        rdc("pin setup rw", acsc_pkg::IDX_PIN_SETUP, 32'hf8);
        chk("trigger default", 1, trg);
        $display("test reset done");
    endtask : t_reset

    task automatic t_status();
        code <= 3'h5;
        fgd  <= 1'b1;
        tick(3);
        rdc("status fg", acsc_pkg::IDX_STATUS, 32'h17);
        wr(acsc_pkg::IDX_STATUS, 8'hff);
        rdc("status after write", acsc_pkg::IDX_STATUS, 32'h17);
        fgd <= 1'b0;
        bre <= 1'b1;
        hlt <= 1'b1;
        tick(4);
        rdc("stopped halted", acsc_pkg::IDX_STATUS, 32'h17);
        hlt <= 1'b0;
        tick(4);
        rdc("stopped running", acsc_pkg::IDX_STATUS, 32'h15);
        $display("test status done");
    endtask : t_status

    // Two flag states so selector codes 0 to 2 each show a difference
    task automatic t_pin();
        for (int st = 0; st < 2; st++) begin
            if (st == 1) begin
                rsr <= 1'b1;
                hlt <= 1'b1;
                alm <= 1'b1;
                tick(1);
                rsr <= 1'b0;
            end
            for (int s = 0; s < 4; s++) begin
                wr(acsc_pkg::IDX_PIN_SETUP, 8'(s << 1));
                tick(3);
                chk("status pin", 32'((s == 0) ? 1 - st : (s == 3) ? 0 : st), stp);
            end
        end
        $display("test pin done");
    endtask : t_pin

    task automatic t_trig();
        hwp <= 1'b0;
        tick(6);
        chk("soft high", 1, trg);
        wr(acsc_pkg::IDX_SOFT_KICK, 8'h00);
        hwp <= 1'b1;
        tick(6);
        chk("soft low", 0, trg);
        wr(acsc_pkg::IDX_PIN_SETUP, 8'h01);
        tick(6);
        chk("pin high", 1, trg);
        hwp <= 1'b0;
        wr(acsc_pkg::IDX_SOFT_KICK, 8'h01);
        tick(6);
        chk("pin low", 0, trg);
        wr(acsc_pkg::IDX_PIN_SETUP, 8'h00);
        tick(3);
        chk("soft again", 1, trg);
        $display("test trigger done");
    endtask : t_trig

    task automatic t_irq();
        wr(acsc_pkg::IDX_IRQ_STATUS, 8'h0f);
        rdc("irq cleared", acsc_pkg::IDX_IRQ_STATUS, 32'h0);
        wr(acsc_pkg::IDX_IRQ_MASK, 8'h01);
        tick(3);
        chk("irq idle", 0, irq);
        fgd <= 1'b1;
        tick(1);
        fgd <= 1'b0;
        tick(3);
        chk("irq raised", 1, irq);
        wr(acsc_pkg::IDX_IRQ_MASK, 8'h00);
        tick(3);
        chk("irq masked", 0, irq);
        rdc("irq sticky", acsc_pkg::IDX_IRQ_STATUS, 32'h1);
        wr(acsc_pkg::IDX_IRQ_STATUS, 8'h01);
        rdc("irq w1c", acsc_pkg::IDX_IRQ_STATUS, 32'h0);
        $display("test irq done");
    endtask : t_irq

    // Exponent cap 3 makes codes 4 and 1 last 9 x 256 cycles
    task automatic t_lp();
        wr(acsc_pkg::IDX_LP_CTRL, 8'h89);
        for (n = 0; slp !== 1'b1 && n < 100; n++) @(posedge mclk);
        for (n = 0; stl !== 1'b1 && n < 5000; n++) @(posedge mclk);
        chk("sleep length", 2304, n);
        for (n = 0; creq !== 1'b1 && n < 5000; n++) @(posedge mclk);
        chk("settle length", 2304, n);
        tick(5);
        chk("request held", 1, creq);
        ccd <= 1'b1;
        tick(1);
        ccd <= 1'b0;
        tick(3);
        chk("sleep again", 1, slp);
        wr(acsc_pkg::IDX_LP_CTRL, 8'h8b);
        tick(3000);
        chk("wait on trigger", 1, slp);
        wr(acsc_pkg::IDX_SOFT_KICK, 8'h00);
        tick(8);
        chk("woken by trigger", 1, stl);
        bre <= 1'b0;
        tick(4);
        chk("lp off", 0, {slp, stl, creq});
        $display("test low power done");
    endtask : t_lp

    // ==========================================================
    // Main sequence
    initial begin
        tick(4);
        rst <= 1'b0;
        tick(1);
        t_reset();
        t_status();
        t_pin();
        t_trig();
        t_irq();
        t_lp();
        end_sim();
    end
endmodule : acsc_top_tb
